// >>> tbdm_defs.svh
// Address map, page and bank limits, reset values and timing counts.
`ifndef TBDM_DEFS_SVH
`define TBDM_DEFS_SVH
`define TBDM_ADDR_IND0     8'h00
`define TBDM_ADDR_PTR0     8'h01
`define TBDM_ADDR_IND1     8'h02
`define TBDM_ADDR_PTR1     8'h03
`define TBDM_ADDR_BANK     8'h04
`define TBDM_ADDR_TPTR     8'h07
`define TBDM_ADDR_THIGH    8'h08
`define TBDM_SFR_LAST      8'h2f
`define TBDM_GP_BASE       8'h40
`define TBDM_LAST_PAGE     4'hf
`define TBDM_BANKS         6
`define TBDM_BANK_RST      3'h0
`define TBDM_TABLE_CYCLES  2
`define TBDM_ZERO_BYTE     8'h00
`endif

// >>> tbdm_pkg.sv
// Types shared by the table-read and data-memory block.
package tbdm_pkg;
  typedef enum logic [2:0] {
    TBDM_IDLE  = 3'b001,
    TBDM_FETCH = 3'b010,
    TBDM_STORE = 3'b100
  } tbdm_state_type;
endpackage : tbdm_pkg

// >>> tbdm_mem_if.sv
// Port bundle between the core logic and the general-purpose memory.
`timescale 1ns/1ns
interface tbdm_mem_if #(parameter int AW = 11);
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface : tbdm_mem_if

// >>> tbdm_ram.sv
// Banked general-purpose data memory with registered read data.
`timescale 1ns/1ns
module tbdm_ram #(
  parameter int AW = 11
) (
  input  wire logic CLK_I,
  tbdm_mem_if.mem   port
);
  logic [7:0] store [0:(1<<AW)-1];
  logic [7:0] rd;
  // Contents are never cleared; software must initialise what it uses.
  always_ff @(posedge CLK_I) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    rd <= store[port.addr];
  end
  assign port.rdata = rd;
endmodule : tbdm_ram

// >>> tbdm_core.sv
// Table-read address formation and banked data-memory access logic.
// What this block does
// - Current-page table read uses PC bits 11..8 above table pointer.
// - Last-page table read forces upper four address bits to ones.
// - Table read loads fetched upper byte into the high-byte holder.
// - High-byte holder is read-only; program writes are ignored.
// - Every table instruction takes two instruction cycles to complete.
// - Data memory is 8 bits wide, consecutive from address zero.
// - Six general-purpose banks chosen by the bank select pointer.
// - Direct accesses reach only bank 0.
// - Pointer zero indirection hits bank 0; pointer one reaches banks 0-5.
// - Unused special locations and the reserved gap read as zero.
// - Special registers stay reachable whatever bank is selected.
// - Single-bit set and clear keep the other bits unchanged.
// - Read-only special registers ignore program writes.
// - Table read writes fetched low byte to the named general-purpose location in bank 0.
// - Indirect ports use their pointer; self-indirection reads zero, no write.
// - Bank pointer resets to 0 except watchdog wake from power-down.
`timescale 1ns/1ns
`include "tbdm_defs.svh"
module tbdm_core
  import tbdm_pkg::*;
#(
  parameter int AW = 11
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        WDT_SLEEP_RESET_I,
  input  wire logic        RD_I,
  input  wire logic        WR_I,
  input  wire logic        BIT_SET_I,
  input  wire logic        BIT_CLR_I,
  input  wire logic [2:0]  BIT_SEL_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        TPTR_INC_I,
  input  wire logic        TPTR_DEC_I,
  input  wire logic        TABLE_CUR_I,
  input  wire logic        TABLE_LAST_I,
  input  wire logic [7:0]  TABLE_DEST_I,
  input  wire logic [3:0]  PC_HIGH_I,
  input  wire logic [15:0] PROG_WORD_I,
  output logic      [11:0] PROG_ADDR_O,
  output logic             PROG_RD_O,
  output logic      [7:0]  RDATA_O,
  output logic             RVALID_O,
  output logic             BUSY_O,
  output logic             DONE_O,
  output logic      [7:0]  TABLE_HIGH_O,
  output logic      [2:0]  BANK_O
);
  logic [7:0]     memory_pointer_zero;
  logic [7:0]     memory_pointer_one;
  logic [2:0]     bank_select_pointer;
  logic [7:0]     table_pointer;
  logic [7:0]     table_high_byte_holder;
  tbdm_state_type state;
  logic [7:0]     dest;
  logic           rd_pend;
  logic           rd_from_mem;
  logic [7:0]     rd_sfr;
  logic           bit_op;
  logic           bit_wb;
  logic [2:0]     bit_idx;
  logic           bit_val;
  logic [7:0]     eff_addr;
  logic [2:0]     eff_bank;
  logic           eff_void;
  logic           eff_gp;
  logic [7:0]     sfr_val;
  logic           sfr_hit;
  logic           bank_rst_n;

  tbdm_mem_if #(.AW(AW)) mif ();
  tbdm_ram #(.AW(AW)) u_ram (.CLK_I(CLK_I), .port(mif.mem));

  assign bit_op = BIT_SET_I | BIT_CLR_I;

  // Resolve indirection: each port addresses the location in its pointer.
  always_comb begin
    eff_addr = ADDR_I;
    eff_bank = 3'h0;
    eff_void = 1'b0;
    if (ADDR_I == `TBDM_ADDR_IND0) begin
      eff_addr = memory_pointer_zero;
      eff_bank = 3'h0;
    end else if (ADDR_I == `TBDM_ADDR_IND1) begin
      eff_addr = memory_pointer_one;
      eff_bank = bank_select_pointer;
    end
    if ((ADDR_I == `TBDM_ADDR_IND0 || ADDR_I == `TBDM_ADDR_IND1) &&
        (eff_addr == `TBDM_ADDR_IND0 || eff_addr == `TBDM_ADDR_IND1)) begin
      eff_void = 1'b1;
    end
  end

  // Special registers live below the general area in every bank.
  assign eff_gp = (eff_addr >= `TBDM_GP_BASE);

  always_comb begin
    sfr_hit = 1'b1;
    case (eff_addr)
      `TBDM_ADDR_PTR0:  sfr_val = memory_pointer_zero;
      `TBDM_ADDR_PTR1:  sfr_val = memory_pointer_one;
      `TBDM_ADDR_BANK:  sfr_val = {5'h00, bank_select_pointer};
      `TBDM_ADDR_TPTR:  sfr_val = table_pointer;
      `TBDM_ADDR_THIGH: sfr_val = table_high_byte_holder;
      default: begin
        sfr_val = `TBDM_ZERO_BYTE;
        sfr_hit = 1'b0;
      end
    endcase
  end

  // Memory port: table store, bit write-back or plain access.
  always_comb begin
    mif.we    = 1'b0;
    mif.wdata = WDATA_I;
    mif.addr  = AW'({eff_bank, eff_addr});
    if (state == TBDM_STORE) begin
      mif.addr  = AW'({3'h0, dest});
      mif.wdata = PROG_WORD_I[7:0];
      mif.we    = (dest >= `TBDM_GP_BASE);
    end else if (bit_wb) begin
      mif.wdata = mif.rdata;
      mif.wdata[bit_idx] = bit_val;
      mif.we    = 1'b1;
    end else if (WR_I && eff_gp && !eff_void) begin
      mif.we    = 1'b1;
    end
  end

  // Bit operations read the byte, then write it back one cycle later.
  // The caller must hold the address steady for both cycles.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bit_wb  <= 1'b0;
      bit_idx <= 3'h0;
      bit_val <= 1'b0;
    end else begin
      bit_wb  <= bit_op && !bit_wb && eff_gp && !eff_void;
      bit_idx <= BIT_SEL_I;
      bit_val <= BIT_SET_I;
    end
  end

  // Special register writes. Read-only registers have no program write path,
  // so a program write can never disturb them.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      memory_pointer_zero <= `TBDM_ZERO_BYTE;
      memory_pointer_one  <= `TBDM_ZERO_BYTE;
      table_pointer       <= `TBDM_ZERO_BYTE;
    end else begin
      if (WR_I && !eff_void && eff_addr == `TBDM_ADDR_PTR0) begin
        memory_pointer_zero <= WDATA_I;
      end
      if (WR_I && !eff_void && eff_addr == `TBDM_ADDR_PTR1) begin
        memory_pointer_one <= WDATA_I;
      end
      if (WR_I && !eff_void && eff_addr == `TBDM_ADDR_TPTR) begin
        table_pointer <= WDATA_I;
      end else if (TPTR_INC_I) begin
        table_pointer <= table_pointer + 8'h01;
      end else if (TPTR_DEC_I) begin
        table_pointer <= table_pointer - 8'h01;
      end
    end
  end

  // A watchdog wake from sleep leaves the bank pointer as it was, so its
  // reset is gated. The wake flag must be steady before reset falls,
  // otherwise the gated reset could glitch.
  assign bank_rst_n = RST_N_I | WDT_SLEEP_RESET_I;

  always_ff @(posedge CLK_I or negedge bank_rst_n) begin
    if (!bank_rst_n) begin
      bank_select_pointer <= `TBDM_BANK_RST;
    end else if (WR_I && !eff_void && eff_addr == `TBDM_ADDR_BANK) begin
      if (WDATA_I < 8'(`TBDM_BANKS)) begin
        bank_select_pointer <= WDATA_I[2:0];
      end
    end
  end
  // Table read sequencer: fetch cycle, then store cycle.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state                  <= TBDM_IDLE;
      dest                   <= `TBDM_ZERO_BYTE;
      PROG_ADDR_O            <= 12'h000;
      PROG_RD_O              <= 1'b0;
      DONE_O                 <= 1'b0;
      table_high_byte_holder <= `TBDM_ZERO_BYTE;
    end else begin
      DONE_O    <= 1'b0;
      PROG_RD_O <= 1'b0;
      case (state)
        TBDM_IDLE: begin
          if (TABLE_CUR_I || TABLE_LAST_I) begin
            dest        <= TABLE_DEST_I;
            PROG_RD_O   <= 1'b1;
            PROG_ADDR_O <= TABLE_LAST_I ?
                           {`TBDM_LAST_PAGE, table_pointer} :
                           {PC_HIGH_I, table_pointer};
            state       <= TBDM_FETCH;
          end
        end
        TBDM_FETCH: begin
          state <= TBDM_STORE;
        end
        TBDM_STORE: begin
          table_high_byte_holder <= PROG_WORD_I[15:8];
          DONE_O <= 1'b1;
          state  <= TBDM_IDLE;
        end
        default: state <= TBDM_IDLE;
      endcase
    end
  end

  // Read answer: registers and memory data are both captured now, presented one cycle later.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_pend     <= 1'b0;
      rd_from_mem <= 1'b0;
      rd_sfr      <= `TBDM_ZERO_BYTE;
      RDATA_O     <= `TBDM_ZERO_BYTE;
      RVALID_O    <= 1'b0;
    end else begin
      rd_pend     <= RD_I;
      rd_from_mem <= eff_gp && !eff_void;
      rd_sfr      <= (eff_void || !sfr_hit) ? `TBDM_ZERO_BYTE : sfr_val;
      RVALID_O    <= rd_pend;
      if (rd_pend) begin
        RDATA_O <= rd_from_mem ? mif.rdata : rd_sfr;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BUSY_O       <= 1'b0;
      TABLE_HIGH_O <= `TBDM_ZERO_BYTE;
      BANK_O       <= `TBDM_BANK_RST;
    end else begin
      BUSY_O       <= (state == TBDM_IDLE) ?
                      (TABLE_CUR_I || TABLE_LAST_I) :
                      (state == TBDM_FETCH);
      TABLE_HIGH_O <= table_high_byte_holder;
      BANK_O       <= bank_select_pointer;
    end
  end
endmodule : tbdm_core

// >>> tbdm_prog_model.sv
// Program memory model that answers the block's table fetches.
`timescale 1ns/1ns
module tbdm_prog_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [11:0] addr_i,
  output logic      [15:0] word_o
);
  // The word lands one edge after the strobe and holds until the next one,
  // so it is settled one cycle after the strobe rises.
  initial word_o = 16'h0000;
  always @(posedge clk_i) begin
    if (rd_i) begin
      word_o <= {addr_i[11:8], 4'h3, addr_i[7:0]};
    end
  end
endmodule : tbdm_prog_model

// >>> tbdm_core_sva.sv
// Concurrent checks on the ports of the table-read and data-memory block.
`timescale 1ns/1ns
module tbdm_core_sva (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        WDT_SLEEP_RESET_I,
  input wire logic        RD_I,
  input wire logic        TABLE_CUR_I,
  input wire logic        TABLE_LAST_I,
  input wire logic [3:0]  PC_HIGH_I,
  input wire logic [11:0] PROG_ADDR_O,
  input wire logic        PROG_RD_O,
  input wire logic        RVALID_O,
  input wire logic        BUSY_O,
  input wire logic        DONE_O,
  input wire logic [7:0]  TABLE_HIGH_O,
  input wire logic [2:0]  BANK_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_cur_page: assert property (
    TABLE_CUR_I |=> PROG_RD_O && PROG_ADDR_O[11:8] == $past(PC_HIGH_I))
    else $error("current page address wrong");
  a_last_page: assert property (
    TABLE_LAST_I |=> PROG_RD_O && PROG_ADDR_O[11:8] == 4'hf)
    else $error("last page address wrong");
  a_table_done: assert property (
    (TABLE_CUR_I || TABLE_LAST_I) |-> ##3 DONE_O)
    else $error("table read did not finish in time");
  a_table_busy: assert property (
    (TABLE_CUR_I || TABLE_LAST_I) |=> BUSY_O [*2])
    else $error("busy dropped during table read");
  a_holder_cause: assert property (
    $changed(TABLE_HIGH_O) |-> DONE_O || $past(DONE_O) || $past(DONE_O, 2))
    else $error("high byte holder changed without a table read");
  a_read_answer: assert property (
    RD_I |-> ##2 RVALID_O)
    else $error("read answer late");
  a_bank_range: assert property (BANK_O < 3'h6)
    else $error("bank pointer out of range");
  a_bank_reset: assert property (
    $rose(RST_N_I) && !WDT_SLEEP_RESET_I |=> BANK_O == 3'h0)
    else $error("bank pointer not cleared by reset");
  a_fetch_pulse: assert property (PROG_RD_O |=> !PROG_RD_O)
    else $error("fetch strobe longer than one cycle");
  a_done_pulse: assert property (DONE_O |=> !DONE_O)
    else $error("done strobe longer than one cycle");
endmodule : tbdm_core_sva
bind tbdm_core tbdm_core_sva u_tbdm_core_sva (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .WDT_SLEEP_RESET_I(WDT_SLEEP_RESET_I),
  .RD_I(RD_I), .TABLE_CUR_I(TABLE_CUR_I), .TABLE_LAST_I(TABLE_LAST_I),
  .PC_HIGH_I(PC_HIGH_I), .PROG_ADDR_O(PROG_ADDR_O), .PROG_RD_O(PROG_RD_O),
  .RVALID_O(RVALID_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
  .TABLE_HIGH_O(TABLE_HIGH_O), .BANK_O(BANK_O));

// >>> tb_top.sv
// Self-checking bench for the table-read and data-memory block.
`timescale 1ns/1ns
`include "tbdm_defs.svh"
module tb_top;
  logic        clk, rst_n, rd, wr, bset, bclr, tinc, tdec, tcur, tlast, wdt;
  logic        prd, rvalid, busy, done;
  logic [2:0]  bsel, bank;
  logic [3:0]  pch;
  logic [7:0]  addr, wdata, dest, rdata, thigh;
  logic [11:0] paddr;
  logic [15:0] word;
  int          n_mismatch, n_checks, cyc;
  tbdm_core u_tbdm_core (.CLK_I(clk), .RST_N_I(rst_n), .WDT_SLEEP_RESET_I(wdt),
    .RD_I(rd), .WR_I(wr), .BIT_SET_I(bset), .BIT_CLR_I(bclr), .BIT_SEL_I(bsel),
    .ADDR_I(addr), .WDATA_I(wdata), .TPTR_INC_I(tinc), .TPTR_DEC_I(tdec),
    .TABLE_CUR_I(tcur), .TABLE_LAST_I(tlast), .TABLE_DEST_I(dest),
    .PC_HIGH_I(pch), .PROG_WORD_I(word), .PROG_ADDR_O(paddr), .PROG_RD_O(prd),
    .RDATA_O(rdata), .RVALID_O(rvalid), .BUSY_O(busy), .DONE_O(done),
    .TABLE_HIGH_O(thigh), .BANK_O(bank));
  tbdm_prog_model u_tbdm_prog_model (.clk_i(clk), .rd_i(prd), .addr_i(paddr),
    .word_o(word));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk({15'h0000, rvalid}, 16'h0001);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd_reg
  task automatic bitop(input logic set, input logic [7:0] a,
                       input logic [2:0] s);
    @(negedge clk);
    bset = set;
    bclr = !set;
    bsel = s;
    addr = a;
    repeat (2) @(negedge clk);
    bset = 1'b0;
    bclr = 1'b0;
  endtask : bitop
  task automatic step(input logic up);
    @(negedge clk);
    tinc = up;
    tdec = !up;
    @(negedge clk);
    tinc = 1'b0;
    tdec = 1'b0;
  endtask : step
  // Table reads never overlap: each waits out its store cycle first.
  task automatic tab(input logic last, input logic [7:0] d,
                     input logic [11:0] ea);
    @(negedge clk);
    tlast = last;
    tcur = !last;
    dest = d;
    @(negedge clk);
    tlast = 1'b0;
    tcur = 1'b0;
    chk({15'h0000, prd}, 16'h0001);
    chk({4'h0, paddr}, {4'h0, ea});
    chk({15'h0000, busy}, 16'h0001);
    repeat (2) @(negedge clk);
    chk({15'h0000, done}, 16'h0001);
    repeat (2) @(negedge clk);
  endtask : tab
  initial begin
    {wdt, rst_n, rd, wr, bset, bclr, tinc, tdec, tcur, tlast} = 10'h000;
    {bsel, addr, wdata, dest} = 27'h0;
    pch = 4'h9;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk({13'h0000, bank}, 16'h0000);
    rd_reg(`TBDM_ADDR_BANK, 8'h00);
    rd_reg(8'h05, 8'h00);
    rd_reg(8'h30, 8'h00);
    $display("test reset done");
    wr_reg(`TBDM_ADDR_BANK, 8'h02);
    wr_reg(8'h40, 8'h11);
    wr_reg(`TBDM_ADDR_PTR1, 8'h40);
    wr_reg(`TBDM_ADDR_IND1, 8'h22);
    wr_reg(`TBDM_ADDR_BANK, 8'h05);
    wr_reg(`TBDM_ADDR_IND1, 8'h55);
    rd_reg(`TBDM_ADDR_IND1, 8'h55);
    wr_reg(`TBDM_ADDR_BANK, 8'h02);
    rd_reg(8'h40, 8'h11);
    rd_reg(`TBDM_ADDR_IND1, 8'h22);
    rd_reg(`TBDM_ADDR_PTR1, 8'h40);
    wr_reg(`TBDM_ADDR_PTR0, 8'h40);
    rd_reg(`TBDM_ADDR_IND0, 8'h11);
    wr_reg(`TBDM_ADDR_BANK, 8'h06);
    rd_reg(`TBDM_ADDR_BANK, 8'h02);
    wr_reg(`TBDM_ADDR_PTR0, `TBDM_ADDR_IND0);
    rd_reg(`TBDM_ADDR_IND0, 8'h00);
    $display("test banks done");
    wr_reg(8'h41, 8'ha5);
    bitop(1'b1, 8'h41, 3'h1);
    rd_reg(8'h41, 8'ha7);
    bitop(1'b0, 8'h41, 3'h7);
    rd_reg(8'h41, 8'h27);
    wr_reg(`TBDM_ADDR_TPTR, 8'hff);
    step(1'b1);
    rd_reg(`TBDM_ADDR_TPTR, 8'h00);
    step(1'b0);
    rd_reg(`TBDM_ADDR_TPTR, 8'hff);
    $display("test bits done");
    wr_reg(`TBDM_ADDR_BANK, 8'h03);
    @(negedge clk);
    wdt = 1'b1;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    wdt = 1'b0;
    chk({13'h0000, bank}, 16'h0003);
    rd_reg(`TBDM_ADDR_BANK, 8'h03);
    $display("test watchdog reset done");
    wr_reg(`TBDM_ADDR_BANK, 8'h00);
    wr_reg(`TBDM_ADDR_TPTR, 8'h06);
    tab(1'b1, 8'h50, 12'hf06);
    chk({8'h00, thigh}, 16'h00f3);
    rd_reg(8'h50, 8'h06);
    tab(1'b0, 8'h51, 12'h906);
    rd_reg(`TBDM_ADDR_THIGH, 8'h93);
    wr_reg(`TBDM_ADDR_THIGH, 8'h00);
    rd_reg(`TBDM_ADDR_THIGH, 8'h93);
    rd_reg(8'h51, 8'h06);
    wr_reg(`TBDM_ADDR_TPTR, 8'hff);
    step(1'b1);
    tab(1'b1, 8'h52, 12'hf00);
    rd_reg(8'h52, 8'h00);
    $display("test table done");
    end_of_test();
  end
endmodule : tb_top
